//--- rtl/vgc_regs.v
// Glyph pointer, cursor, indicator and configuration register logic with serial command port
`timescale 1ns/100ps
`include "vgc_defines.vh"
// Operation
// - Glyph byte 0 drives a..g1, byte 1 drives g2,h..m; ignored on 7-segment
// - Writing 0x80 to command 0x05 zeroes glyph address; also power-up value
// - Top glyph address 47 set by 0xAF; address is value minus 0x80
// - Glyph pointer writes 0xB0 to 0xFF reset the pointer to zero
// - Read at 0x85 returns current glyph address pointer
// - Cursor register 0x0F: D7 blink, D6..D0 position; blink clear means steady
// - Blinking cursor lit only in first half of blink period
// - Cursor positions 0-47 first row, 48-95 second row, 96 up none
// - Indicator code 00 dark, 11 lit continuously
// - Code 01 lit first half, code 10 lit second half
// - Indicator fields one to four at D1:D0, D3:D2, D5:D4, D7:D6
// - Config bits: phase, mode, clear, sync, font, rate, lock, run
// - Config D0 low means shutdown, high means normal running
// - Shutdown stops mux at period end, blanks tubes, keeps registers writable
// - After shutdown, blank tubes for one full mux cycle then resume; the code blanks a whole scan of MUX_PER_SCAN mux periods
// - Config read returns live blink phase in D7
// - At top pointer, glyph data ignored after the next access
module vgc_regs #(
	parameter SLOW_HALF    = `VGC_SLOW_HALF_CYC,
	parameter FAST_HALF    = `VGC_FAST_HALF_CYC,
	parameter MUX_PER_SCAN = `VGC_MUX_PER_SCAN
) (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire        cs_n,
	input  wire        sclk,
	input  wire        din,
	output reg         dout,
	input  wire        glyph_access,
	input  wire [1:0]  digit_type,
	input  wire [6:0]  glyph_byte0,
	input  wire [6:0]  glyph_byte1,
	input  wire        mux_digit_row,
	input  wire [5:0]  mux_digit_index,
	output reg  [5:0]  user_glyph_slot,
	output reg         glyph_data_ignore,
	output reg  [13:0] segment_out,
	output reg         cursor_lit,
	output reg         indicator_one,
	output reg         indicator_two,
	output reg         indicator_three,
	output reg         indicator_four,
	output reg         tube_blank_out,
	output reg         mux_period_tick,
	output reg  [7:0]  config_out
);
	// ----------------------------------------
	// States and registers
	// ----------------------------------------
	localparam ST_RUN  = 2'h0;
	localparam ST_STOP = 2'h1;
	localparam ST_HALT = 2'h2;
	localparam ST_WAKE = 2'h3;

	reg        sclk_q;
	reg        cs_q;
	reg [15:0] shift_in;
	reg [4:0]  bit_cnt;
	reg [7:0]  shift_out;
	reg [7:0]  glyph_ptr;
	reg [7:0]  cursor_control;
	reg [7:0]  indicator_blink_fields;
	reg [7:0]  device_configuration;
	reg        at_top_used;
	reg [23:0] blink_cnt;
	reg        blink_phase;
	reg [9:0]  mux_cnt;
	reg [5:0]  scan_cnt;
	reg [1:0]  pwr_state;
	reg [1:0]  next_pwr_state;
	reg [7:0]  rd_data;

	wire       sclk_rise  = sclk & ~sclk_q & ~cs_n;
	wire       frame_end  = cs_n & ~cs_q & (bit_cnt == `VGC_FRAME_BITS);
	wire       is_read    = shift_in[`VGC_CMD_RD_BIT];
	wire [6:0] cmd_addr   = shift_in[14:8];
	wire [7:0] cmd_data   = shift_in[7:0];
	wire       wr_en      = frame_end & ~is_read;
	wire       mux_end    = (mux_cnt == (`VGC_MUX_CYCLES - 1));
	wire       scan_end   = mux_end & (scan_cnt == (MUX_PER_SCAN - 1));
	wire [31:0] half_sel  = device_configuration[`VGC_CFG_RATE] ? FAST_HALF : SLOW_HALF;
	wire [23:0] half_len  = half_sel[23:0];
	// Positions run on across both rows, so the second row starts above the first row's top digit
	wire        cur_second = (cursor_control[`VGC_CUR_POS_MSB:0] >= `VGC_CUR_ROW2_BASE);
	wire [6:0]  cur_digit  = cur_second ? cursor_control[`VGC_CUR_POS_MSB:0] - `VGC_CUR_ROW2_BASE
	                                    : cursor_control[`VGC_CUR_POS_MSB:0];

	// Lit state of one two-bit indicator field from the shared phase
	function ind_lit;
		input [1:0] code;
		input       phase;
		begin
			case (code)
				`VGC_IND_OFF:    ind_lit = 1'b0;
				`VGC_IND_FIRST:  ind_lit = phase;
				`VGC_IND_SECOND: ind_lit = ~phase;
				default:         ind_lit = 1'b1;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Serial command port
	// ----------------------------------------
	// Pins treated as synchronous; sclk must stay well below mclk/2
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q    <= 1'b0;
			cs_q      <= 1'b1;
			shift_in  <= 16'h0000;
			bit_cnt   <= 5'h00;
			shift_out <= 8'h00;
			dout      <= 1'b0;
		end else begin
			sclk_q <= sclk;
			cs_q   <= cs_n;
			if (cs_n && !cs_q) begin
				bit_cnt <= 5'h00;
				if (frame_end && is_read) begin
					shift_out <= rd_data;
					dout      <= rd_data[7];
				end
			end else if (sclk_rise) begin
				shift_in <= {shift_in[14:0], din};
				if (bit_cnt != `VGC_FRAME_BITS)
					bit_cnt <= bit_cnt + 5'h01;
				shift_out <= {shift_out[6:0], 1'b0};
				dout      <= shift_out[6];
			end
		end
	end

	always @* begin
		case (cmd_addr)
			`VGC_ADDR_GLYPH_PTR: rd_data = glyph_ptr - `VGC_PTR_BASE;
			`VGC_ADDR_CURSOR:    rd_data = cursor_control;
			`VGC_ADDR_INDICATOR: rd_data = indicator_blink_fields;
			`VGC_ADDR_CONFIG:    rd_data = {blink_phase, device_configuration[6:0]};
			default:             rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Register writes and glyph pointer
	// ----------------------------------------
	// Writes stay accepted during shutdown
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			glyph_ptr              <= `VGC_PTR_BASE;
			at_top_used            <= 1'b0;
			cursor_control         <= `VGC_CUR_RESET;
			indicator_blink_fields <= `VGC_IND_RESET;
			device_configuration   <= `VGC_CFG_RESET;
		end else begin
			if (wr_en && cmd_addr == `VGC_ADDR_GLYPH_PTR) begin
				at_top_used <= 1'b0;
				if (cmd_data >= `VGC_PTR_BASE && cmd_data <= `VGC_PTR_TOP)
					glyph_ptr <= cmd_data;
				else
					glyph_ptr <= `VGC_PTR_BASE;
			end else if (glyph_access) begin
				if (glyph_ptr == `VGC_PTR_TOP)
					at_top_used <= 1'b1;
				else
					glyph_ptr <= glyph_ptr + 8'h01;
			end
			if (wr_en && cmd_addr == `VGC_ADDR_CURSOR)
				cursor_control <= cmd_data;
			if (wr_en && cmd_addr == `VGC_ADDR_INDICATOR)
				indicator_blink_fields <= cmd_data;
			if (wr_en && cmd_addr == `VGC_ADDR_CONFIG)
				device_configuration <= cmd_data;
		end
	end

	// ----------------------------------------
	// Shared blink phase
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt   <= 24'h000000;
			blink_phase <= 1'b1;
		end else if (wr_en && cmd_addr == `VGC_ADDR_CONFIG && cmd_data[`VGC_CFG_SYNC]) begin
			blink_cnt   <= 24'h000000;
			blink_phase <= 1'b1;
		end else if (blink_cnt >= half_len - 24'h000001) begin
			blink_cnt   <= 24'h000000;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 24'h000001;
		end
	end

	// ----------------------------------------
	// Multiplex timing and shutdown
	// ----------------------------------------
	always @* begin
		case (pwr_state)
			ST_RUN:  next_pwr_state = device_configuration[`VGC_CFG_RUN] ? ST_RUN : ST_STOP;
			ST_STOP: next_pwr_state = mux_end ? ST_HALT : ST_STOP;
			ST_HALT: next_pwr_state = device_configuration[`VGC_CFG_RUN] ? ST_WAKE : ST_HALT;
			ST_WAKE: next_pwr_state = scan_end ? ST_RUN : ST_WAKE;
			default: next_pwr_state = ST_HALT;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_state       <= ST_HALT;
			mux_cnt         <= 10'h000;
			scan_cnt        <= 6'h00;
			mux_period_tick <= 1'b0;
			tube_blank_out  <= 1'b1;
		end else begin
			pwr_state <= next_pwr_state;
			// Wake restarts the scan so the blanked cycle is a whole one
			if (pwr_state == ST_HALT) begin
				mux_cnt  <= 10'h000;
				scan_cnt <= 6'h00;
			end else if (mux_end) begin
				mux_cnt  <= 10'h000;
				scan_cnt <= scan_end ? 6'h00 : scan_cnt + 6'h01;
			end else begin
				mux_cnt <= mux_cnt + 10'h001;
			end
			mux_period_tick <= mux_end & (pwr_state != ST_HALT);
			tube_blank_out  <= (next_pwr_state != ST_RUN);
		end
	end

	// ----------------------------------------
	// Display outputs
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			segment_out       <= 14'h0000;
			cursor_lit        <= 1'b0;
			indicator_one     <= 1'b0;
			indicator_two     <= 1'b0;
			indicator_three   <= 1'b0;
			indicator_four    <= 1'b0;
			user_glyph_slot   <= 6'h00;
			glyph_data_ignore <= 1'b0;
			config_out        <= `VGC_CFG_RESET;
		end else begin
			if (digit_type == `VGC_DIGIT_7SEG)
				segment_out <= {glyph_byte0, 7'h00};
			else
				segment_out <= {glyph_byte0, glyph_byte1};
			cursor_lit <= (cursor_control[`VGC_CUR_POS_MSB:0] < `VGC_CUR_NONE_BASE)
				& (mux_digit_row == cur_second)
				& ({1'b0, mux_digit_index} == cur_digit)
				& (~cursor_control[`VGC_CUR_BLINK] | blink_phase);
			indicator_one     <= ind_lit(indicator_blink_fields[1:0], blink_phase);
			indicator_two     <= ind_lit(indicator_blink_fields[3:2], blink_phase);
			indicator_three   <= ind_lit(indicator_blink_fields[5:4], blink_phase);
			indicator_four    <= ind_lit(indicator_blink_fields[7:6], blink_phase);
			user_glyph_slot   <= glyph_ptr[6:1];
			glyph_data_ignore <= at_top_used;
			config_out        <= {blink_phase, device_configuration[6:0]};
		end
	end
endmodule

//--- rtl/vgc_defines.vh
// Command addresses, field positions, reset values and timing for the glyph/cursor/config bank
`ifndef VGC_DEFINES_VH
`define VGC_DEFINES_VH
// ----------------------------------------
// Command addresses
// ----------------------------------------
`define VGC_CMD_RD_BIT      15
`define VGC_ADDR_GLYPH_PTR  7'h05
`define VGC_ADDR_CURSOR     7'h0F
`define VGC_ADDR_INDICATOR  7'h0D
`define VGC_ADDR_CONFIG     7'h04
`define VGC_FRAME_BITS      5'h10
// ----------------------------------------
// Glyph pointer values
// ----------------------------------------
`define VGC_PTR_BASE        8'h80
`define VGC_PTR_TOP         8'hAF
`define VGC_GLYPH_BIT_TOP   6
// ----------------------------------------
// Cursor and configuration fields
// ----------------------------------------
`define VGC_CUR_BLINK       7
`define VGC_CUR_POS_MSB     6
`define VGC_CUR_ROW2_BASE   7'h30
`define VGC_CUR_NONE_BASE   7'h60
`define VGC_CFG_PHASE       7
`define VGC_CFG_SYNC        4
`define VGC_CFG_RATE        2
`define VGC_CFG_RUN         0
`define VGC_CFG_RESET       8'h00
`define VGC_CUR_RESET       8'h00
`define VGC_IND_RESET       8'h00
// ----------------------------------------
// Indicator codes and digit types
// ----------------------------------------
`define VGC_IND_OFF         2'h0
`define VGC_IND_FIRST       2'h1
`define VGC_IND_SECOND      2'h2
`define VGC_IND_ON          2'h3
`define VGC_DIGIT_7SEG      2'h0
// ----------------------------------------
// Timing (10 MHz mclk)
// ----------------------------------------
`define VGC_CLK_MHZ         10
`define VGC_MUX_PERIOD_US   100
`define VGC_MUX_CYCLES      (`VGC_MUX_PERIOD_US * `VGC_CLK_MHZ)
`define VGC_MUX_PER_SCAN    48
`define VGC_SLOW_HALF_MS    1000
`define VGC_FAST_HALF_MS    500
`define VGC_SLOW_HALF_CYC   (`VGC_SLOW_HALF_MS * 1000 * `VGC_CLK_MHZ)
`define VGC_FAST_HALF_CYC   (`VGC_FAST_HALF_MS * 1000 * `VGC_CLK_MHZ)
`endif

//--- bench/vgc_regs_sva.sv
// Assertion checker for the glyph, cursor and configuration bank
`timescale 1ns/100ps
module vgc_regs_sva (
	input wire        mclk,
	input wire        rst_n,
	input wire        cs_n,
	input wire [1:0]  digit_type,
	input wire [6:0]  glyph_byte0,
	input wire [5:0]  user_glyph_slot,
	input wire        glyph_data_ignore,
	input wire [13:0] segment_out,
	input wire        tube_blank_out,
	input wire        mux_period_tick,
	input wire [7:0]  config_out
);
	logic [11:0] shut_cnt;
	// Saturating count of cycles spent in shutdown
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			shut_cnt <= 12'h000;
		else if (config_out[0])
			shut_cnt <= 12'h000;
		else if (shut_cnt != 12'hFFF)
			shut_cnt <= shut_cnt + 12'h001;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_seg_basic_map: assert property ($past(rst_n) |-> segment_out[13:7] == $past(glyph_byte0))
		else $error("basic segments not taken from byte 0");
	a_seven_seg_mask: assert property (digit_type == 2'h0 |=> segment_out[6:0] == 7'h00)
		else $error("extra segments driven on 7-segment digit");
	a_slot_range: assert property (user_glyph_slot <= 6'h17)
		else $error("glyph slot beyond top");
	a_ignore_at_top: assert property (glyph_data_ignore |-> user_glyph_slot == 6'h17)
		else $error("glyph data ignored below top address");
	a_blank_in_shut: assert property (!config_out[0] |-> ##[0:1] tube_blank_out)
		else $error("tubes not blanked in shutdown");
	a_wake_blank: assert property ($rose(config_out[0]) |-> tube_blank_out [*8])
		else $error("tubes unblanked right after wake");
	a_tick_pulse: assert property (mux_period_tick |=> !mux_period_tick [*8])
		else $error("period tick too close");
	a_tick_halt: assert property (shut_cnt > 12'h3FC |-> !mux_period_tick)
		else $error("multiplex timing runs in shutdown");
	a_cfg_after_frame: assert property (!$stable(config_out[6:0]) |-> cs_n && $past(cs_n))
		else $error("configuration changed inside a frame");
endmodule
bind vgc_regs vgc_regs_sva vgc_regs_sva_i (.mclk, .rst_n, .cs_n, .digit_type, .glyph_byte0, .user_glyph_slot,
	.glyph_data_ignore, .segment_out, .tube_blank_out, .mux_period_tick, .config_out);

//--- bench/vgc_host_model.sv
// Host side of the serial command port
`timescale 1ns/100ps
module vgc_host_model (
	input  wire  mclk,
	input  wire  dout,
	output logic cs_n,
	output logic sclk,
	output logic din
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	// Slow serial clock: three cycles low, three high, so every rise is seen
	task automatic xfer(input logic [15:0] w, output logic [15:0] got);
		integer i;
		@(posedge mclk) cs_n <= 1'b0;
		for (i = 15; i >= 0; i--) begin
			@(posedge mclk) sclk <= 1'b0;
			din <= w[i];
			repeat (3) @(posedge mclk);
			got[i] = dout;
			sclk <= 1'b1;
			repeat (2) @(posedge mclk);
		end
		@(posedge mclk) sclk <= 1'b0;
		@(posedge mclk) cs_n <= 1'b1;
		din <= ~din;
		repeat (4) @(posedge mclk);
	endtask
endmodule

//--- bench/vgc_regs_tb_top.sv
// Self-checking bench for the glyph, cursor and configuration bank
`timescale 1ns/100ps
module vgc_regs_tb_top;
	logic        mclk = 1'b0, rst_n = 1'b0, glyph_access = 1'b0, mux_digit_row = 1'b0;
	logic [1:0]  digit_type = 2'h0;
	logic [6:0]  glyph_byte0 = 7'h00, glyph_byte1 = 7'h00;
	logic [5:0]  mux_digit_index = 6'h00;
	wire         cs_n, sclk, din, dout, glyph_data_ignore, cursor_lit, tube_blank_out, mux_period_tick;
	wire         indicator_one, indicator_two, indicator_three, indicator_four;
	wire  [5:0]  user_glyph_slot;
	wire  [13:0] segment_out;
	wire  [7:0]  config_out;
	integer      err_total = 0, samples_checked = 0, seed = 32'h7a5210c3, i;
	logic [7:0]  v, r, corner [4] = '{8'h80, 8'hAF, 8'hB0, 8'hFF};
	logic [15:0] g;
	always #50 mclk = ~mclk;
	vgc_regs #(.SLOW_HALF(50), .FAST_HALF(25), .MUX_PER_SCAN(2)) vgc_regs_i (.mclk, .rst_n, .cs_n, .sclk, .din,
		.dout, .glyph_access, .digit_type, .glyph_byte0, .glyph_byte1, .mux_digit_row, .mux_digit_index,
		.user_glyph_slot, .glyph_data_ignore, .segment_out, .cursor_lit, .indicator_one, .indicator_two,
		.indicator_three, .indicator_four, .tube_blank_out, .mux_period_tick, .config_out);
	vgc_host_model vgc_host_model_i (.mclk, .dout, .cs_n, .sclk, .din);
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		vgc_host_model_i.xfer({1'b0, a, d}, g);
	endtask
	// Read data comes out during the following frame, a no-op to an unused address
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		vgc_host_model_i.xfer({1'b1, a, 8'h00}, g);
		vgc_host_model_i.xfer(16'h0000, g);
		d = g[15:8];
	endtask
	task automatic pulse;
		@(posedge mclk) glyph_access <= 1'b1;
		@(posedge mclk) glyph_access <= 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	function automatic logic [7:0] exp_ptr(input logic [7:0] val);
		return (val <= 8'hAF) ? val - 8'h80 : 8'h00;
	endfunction
	// Cursor expectation: linear position over two rows of 48 digits
	function automatic logic exp_cur(input logic [7:0] c, input logic row, input logic [5:0] idx, input logic ph);
		return c[6:0] < 7'h60 && row == (c[6:0] >= 7'h30) && {1'b0, idx} == ((c[6:0] >= 7'h30) ? c[6:0] - 7'h30 : c[6:0])
			&& (!c[7] || ph);
	endfunction
	function automatic logic lit(input logic [1:0] c, input logic ph);
		return c == 2'h3 || (c == 2'h1 && ph) || (c == 2'h2 && !ph);
	endfunction
	// Compare only where the phase has been steady, output latency may differ by a cycle
	task automatic watch(input logic [7:0] ind, input logic [7:0] cur);
		logic [2:0] ph;
		logic [4:0] e;
		ph = 3'h2;
		repeat (120) begin
			@(negedge mclk);
			ph = {ph[1:0], config_out[7]};
			e = {exp_cur(cur, mux_digit_row, mux_digit_index, ph[0]),
				lit(ind[7:6], ph[0]), lit(ind[5:4], ph[0]), lit(ind[3:2], ph[0]), lit(ind[1:0], ph[0])};
			if (ph == 3'h0 || ph == 3'h7)
				check({cursor_lit, indicator_four, indicator_three, indicator_two, indicator_one}, e);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#4000000;
		err_total++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		check({tube_blank_out, user_glyph_slot, config_out[6:0]}, 14'h2000);
		for (i = 0; i < 12; i++) begin
			v = (i < 4) ? corner[i] : 8'h80 | 8'($random(seed));
			wr(7'h05, v);
			rd(7'h05, r);
			check(r, exp_ptr(v));
			check(user_glyph_slot, exp_ptr(v) >> 1);
		end
		wr(7'h05, 8'h80);
		pulse;
		pulse;
		rd(7'h05, r);
		check({r, user_glyph_slot}, 14'h0081);
		wr(7'h05, 8'hAF);
		check(glyph_data_ignore, 1'b0);
		pulse;
		check(glyph_data_ignore, 1'b1);
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			digit_type <= i[1:0];
			{glyph_byte0, glyph_byte1} <= 14'($random(seed));
			@(posedge mclk);
			@(negedge mclk);
			check(segment_out, {glyph_byte0, (digit_type == 2'h0) ? 7'h00 : glyph_byte1});
		end
		wr(7'h04, 8'h01);
		repeat (1900) @(negedge mclk);
		check(tube_blank_out, 1'b1);
		repeat (200) @(negedge mclk);
		check(tube_blank_out, 1'b0);
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hE4 : 8'($random(seed));
			r = 8'($random(seed));
			r = (i == 0) ? 8'hDF : i[0] ? (r | 8'h60) : {r[7], r[6:0] % 7'h60};
			if (i == 4)
				wr(7'h04, 8'h05);
			wr(7'h0D, v);
			wr(7'h0F, r);
			mux_digit_index <= 6'((r[6:0] >= 7'h30) ? r[6:0] - 7'h30 : r[6:0]);
			mux_digit_row <= (r[6:0] >= 7'h30) ^ (i == 2);
			watch(v, r);
		end
		wr(7'h04, 8'h1C);
		@(negedge mclk);
		check(config_out[7], 1'b1);
		repeat (30) @(negedge mclk);
		check(config_out[7], 1'b0);
		rd(7'h04, r);
		check({r[6:0], tube_blank_out}, 8'h39);
		wr(7'h0F, 8'h2A);
		rd(7'h0F, r);
		check(r, 8'h2A);
		rd(7'h0D, r);
		check(r, v);
		rd(7'h10, r);
		check(r, 8'h00);
		repeat (1100) @(negedge mclk);
		g = 16'h0000;
		repeat (1000) @(negedge mclk) g = g + mux_period_tick;
		check(g, 16'h0000);
		final_report;
	end
endmodule
